// ===== hdl/signed_multiply_divide_unit.sv
// Purpose: Signed 16x16 multiply and 32/16 divide sequencer of the instruction option
// Assumes: Host supplies operands at start and performs the register writes we drive
// Notes: One sequencer step per clock; P1..P3 phases fold into one cycle
//
// Overview of operation
// RL1: Odd source register gets the low product, overwriting the high product.
// RL2: Multiply starts at location 601 with multiplier latched in working and copy registers.
// RL3: First step forms count octal 17 in data register and buffer register in the same step.
// RL4: Clear carry, complement multiplier and load counter in one step.
// RL5: Complement still negative means most negative; then multiplier takes multiplicand's place.
// RL6: Test negative multiplicand by subtracting it from held most negative value.
// RL7: Both most negative: skip loop, high is value shifted right, low zero.
// RL8: Decrement count once before the loop for the one-word loop overlap.
// RL9: Each pass adds, subtracts or passes, chosen by low bit and carry, then shifts.
// RL10: Subtract on low bit 1 carry 0, add on 0 and 1, else pass.
// RL11: Sixteen passes, counter decremented each pass until it reads zero, then one last pass.
// RL12: Loop asserts option aux code 2 with base aux code 14.
// RL13: Most-negative path counter test clocks request flags and clears bus busy.
// RL14: High product goes to even source register, low to odd companion.
// RL15: Carry set when the product does not fit in 16 bits.
// RL16: Overflow flag always cleared at end of multiply.
// RL17: Negative flag set when product is below zero.
// RL18: Zero flag set when whole product is zero.
// RL19: Copy local flags into processor status, then return to service point.
// RL20: Divide takes high dividend from even, low from odd, divisor from destination.
// RL21: Quotient to source register, remainder to source index with low bit set.
`timescale 1ns/1ps
`include "muldiv_regs.svh"
module signed_multiply_divide_unit (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic op_div,
	input wire logic [2:0] src_idx,
	input wire logic [15:0] dst_operand,
	input wire logic [15:0] src_data,
	input wire logic [15:0] odd_data,
	output logic busy_r,
	output logic [8:0] ctl_addr_r,
	output logic [3:0] option_aux_control_code_r,
	output logic [4:0] base_aux_control_code_r,
	output logic [3:0] option_branch_test_code_r,
	output logic direct_memory_request_clock_r,
	output logic bus_busy_clear_r,
	output logic reg_we_r,
	output logic [2:0] reg_idx_r,
	output logic [15:0] reg_wdata_r,
	output logic local_negative_flag_r,
	output logic local_zero_flag_r,
	output logic local_overflow_flag_r,
	output logic local_carry_flag_r,
	output logic status_transfer_step_r,
	output logic service_return_r
);
	muldiv_pkg::mdu_state_t state_r, state_nxt;
	logic [15:0] buffer_register_r, buffer_register_nxt;
	logic [15:0] b_r, b_nxt;
	logic [15:0] low_shift_register_r, low_shift_register_nxt;
	logic [15:0] d_r, d_nxt;
	logic [15:0] destination_copy_register_r, destination_copy_register_nxt;
	logic [15:0] src_lat_r, src_lat_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [2:0] sf_r, sf_nxt;
	logic dsign_r, dsign_nxt, qneg_r, qneg_nxt;
	logic busy_nxt, bus_clk_nxt, busy_clr_nxt, we_nxt, psw_nxt, ret_nxt;
	logic [8:0] ctl_nxt;
	logic [3:0] opt_nxt, bt_nxt;
	logic [4:0] base_nxt;
	logic [2:0] idx_nxt;
	logic [15:0] wdata_nxt;
	logic n_nxt, z_nxt, v_nxt, c_nxt;
	logic [15:0] step_br, step_dr;
	logic step_c;
	logic [16:0] shifted;
	logic [31:0] dividend_mag;
	logic [15:0] quo;

	// Negation, shared by multiply and divide
	function automatic logic [15:0] neg16(input logic [15:0] x);
		neg16 = 16'(~x + 16'h0001);
	endfunction

	function automatic logic [15:0] abs16(input logic [15:0] x);
		abs16 = x[15] ? neg16(x) : x;
	endfunction

	// ==========================================================
	// One loop pass of the multiply datapath
	booth_step u_step (
		.br_in(buffer_register_r),
		.b_in(b_r),
		.dr_in(low_shift_register_r),
		.carry_in(local_carry_flag_r),
		.br_out(step_br),
		.dr_out(step_dr),
		.carry_out(step_c)
	);

	// ==========================================================
	// Sequencer next-state and datapath next values
	always_comb begin
		state_nxt = state_r;
		buffer_register_nxt = buffer_register_r;
		b_nxt = b_r;
		low_shift_register_nxt = low_shift_register_r;
		d_nxt = d_r;
		destination_copy_register_nxt = destination_copy_register_r;
		src_lat_nxt = src_lat_r;
		cnt_nxt = cnt_r;
		sf_nxt = sf_r;
		dsign_nxt = dsign_r;
		qneg_nxt = qneg_r;
		ctl_nxt = ctl_addr_r;
		bt_nxt = 4'h0;
		bus_clk_nxt = 1'b0;
		busy_clr_nxt = 1'b0;
		we_nxt = 1'b0;
		idx_nxt = reg_idx_r;
		wdata_nxt = reg_wdata_r;
		psw_nxt = 1'b0;
		ret_nxt = 1'b0;
		n_nxt = local_negative_flag_r;
		z_nxt = local_zero_flag_r;
		v_nxt = local_overflow_flag_r;
		c_nxt = local_carry_flag_r;
		shifted = {buffer_register_r, low_shift_register_r[15]};
		dividend_mag = buffer_register_r[15] ? 32'(~{buffer_register_r, low_shift_register_r} + 32'h1)
			: {buffer_register_r, low_shift_register_r};
		quo = qneg_r ? neg16(low_shift_register_r) : low_shift_register_r;
		case (state_r)
			muldiv_pkg::ST_IDLE: begin
				if (start) begin
					sf_nxt = src_idx;
					src_lat_nxt = src_data;
					b_nxt = dst_operand;
					if (op_div) begin
						buffer_register_nxt = src_data; // [RL20]
						low_shift_register_nxt = odd_data; // [RL20]
						ctl_nxt = `DIV_ENTRY;
						state_nxt = muldiv_pkg::ST_DSET;
					end else begin
						buffer_register_nxt = dst_operand; // [RL2]
						destination_copy_register_nxt = dst_operand; // [RL2]
						ctl_nxt = `MUL_ENTRY; // [RL2]
						state_nxt = muldiv_pkg::ST_MSET;
					end
				end
			end
			muldiv_pkg::ST_MSET: begin
				d_nxt = {10'h000, `ITER_COUNT}; // [RL3]
				buffer_register_nxt = {10'h000, `ITER_COUNT}; // [RL3]
				bt_nxt = `BT_SIGN;
				state_nxt = muldiv_pkg::ST_MCOMP;
			end
			muldiv_pkg::ST_MCOMP: begin
				d_nxt = neg16(b_r); // [RL4]
				c_nxt = 1'b0; // [RL4]
				cnt_nxt = buffer_register_r[5:0]; // [RL4]
				if (b_r[15]) begin
					bt_nxt = `BT_D15;
					state_nxt = muldiv_pkg::ST_MNEG;
				end else begin
					// Positive multiplier stays in B, multiplicand shifts in low register
					low_shift_register_nxt = src_lat_r;
					buffer_register_nxt = 16'h0000;
					cnt_nxt = 6'(buffer_register_r[5:0] - 6'h01); // [RL8]
					state_nxt = muldiv_pkg::ST_MLOOP;
				end
			end
			muldiv_pkg::ST_MNEG: begin
				buffer_register_nxt = 16'h0000;
				d_nxt = src_lat_r;
				if (d_r[15]) begin
					// Most negative can never sit in B, so swap roles
					low_shift_register_nxt = destination_copy_register_r; // [RL5]
					if (src_lat_r[15]) begin
						b_nxt = `MOST_NEG;
						state_nxt = muldiv_pkg::ST_MNN;
					end else begin
						b_nxt = src_lat_r; // [RL5]
						cnt_nxt = 6'(cnt_r - 6'h01); // [RL8]
						state_nxt = muldiv_pkg::ST_MLOOP;
					end
				end else begin
					low_shift_register_nxt = src_lat_r;
					cnt_nxt = 6'(cnt_r - 6'h01); // [RL8]
					state_nxt = muldiv_pkg::ST_MLOOP;
				end
			end
			muldiv_pkg::ST_MNN: begin
				d_nxt = 16'(b_r - src_lat_r); // [RL6]
				bt_nxt = `BT_CNT0;
				bus_clk_nxt = 1'b1; // [RL13]
				busy_clr_nxt = 1'b1; // [RL13]
				if (16'(b_r - src_lat_r) == 16'h0000) begin
					buffer_register_nxt = `MN_SQ_HIGH; // [RL7]
					low_shift_register_nxt = 16'h0000; // [RL7]
					state_nxt = muldiv_pkg::ST_MHI;
				end else begin
					b_nxt = src_lat_r;
					cnt_nxt = 6'(cnt_r - 6'h01); // [RL8]
					state_nxt = muldiv_pkg::ST_MLOOP;
				end
			end
			muldiv_pkg::ST_MLOOP, muldiv_pkg::ST_MLAST: begin
				buffer_register_nxt = step_br; // [RL9]
				low_shift_register_nxt = step_dr;
				c_nxt = step_c;
				// Extra final pass mirrors the lookahead of the one-word loop
				if (state_r == muldiv_pkg::ST_MLAST) begin
					state_nxt = muldiv_pkg::ST_MHI;
				end else if (cnt_r == 6'h00) begin
					state_nxt = muldiv_pkg::ST_MLAST; // [RL11]
				end else begin
					cnt_nxt = 6'(cnt_r - 6'h01); // [RL11]
				end
			end
			muldiv_pkg::ST_MHI: begin
				we_nxt = 1'b1;
				idx_nxt = sf_r; // [RL14]
				wdata_nxt = buffer_register_r; // [RL14]
				bt_nxt = `BT_DR15;
				c_nxt = !((buffer_register_r == 16'h0000 && !low_shift_register_r[15])
					|| (buffer_register_r == 16'hFFFF && low_shift_register_r[15])); // [RL15]
				v_nxt = 1'b0; // [RL16]
				n_nxt = buffer_register_r[15]; // [RL17]
				z_nxt = (buffer_register_r | low_shift_register_r) == 16'h0000; // [RL18]
				state_nxt = muldiv_pkg::ST_MLO;
			end
			muldiv_pkg::ST_MLO: begin
				we_nxt = 1'b1;
				idx_nxt = {sf_r[2:1], 1'b1}; // [RL1] [RL14]
				wdata_nxt = low_shift_register_r; // [RL1]
				state_nxt = muldiv_pkg::ST_FIN;
			end
			muldiv_pkg::ST_DSET: begin
				dsign_nxt = buffer_register_r[15];
				qneg_nxt = buffer_register_r[15] ^ b_r[15];
				n_nxt = 1'b0;
				cnt_nxt = `ITER_COUNT;
				if (b_r == 16'h0000) begin
					// Divide by zero is not executed
					z_nxt = 1'b1;
					v_nxt = 1'b1;
					c_nxt = 1'b1;
					state_nxt = muldiv_pkg::ST_FIN;
				end else if (dividend_mag[31:16] >= abs16(b_r)) begin
					// Quotient cannot fit; registers left untouched
					z_nxt = 1'b0;
					v_nxt = 1'b1;
					c_nxt = 1'b0;
					state_nxt = muldiv_pkg::ST_FIN;
				end else begin
					buffer_register_nxt = dividend_mag[31:16];
					low_shift_register_nxt = dividend_mag[15:0];
					b_nxt = abs16(b_r);
					state_nxt = muldiv_pkg::ST_DLOOP;
				end
			end
			muldiv_pkg::ST_DLOOP: begin
				// Restoring step on magnitudes; remainder stays below divisor
				if (shifted >= {1'b0, b_r}) begin
					buffer_register_nxt = 16'(shifted - {1'b0, b_r});
					low_shift_register_nxt = {low_shift_register_r[14:0], 1'b1};
				end else begin
					buffer_register_nxt = shifted[15:0];
					low_shift_register_nxt = {low_shift_register_r[14:0], 1'b0};
				end
				cnt_nxt = 6'(cnt_r - 6'h01);
				if (cnt_r == 6'h00) begin
					state_nxt = muldiv_pkg::ST_DQUO;
				end
			end
			muldiv_pkg::ST_DQUO: begin
				if (low_shift_register_r[15] && !(qneg_r && low_shift_register_r == `MOST_NEG)) begin
					v_nxt = 1'b1;
					c_nxt = 1'b0;
					state_nxt = muldiv_pkg::ST_FIN;
				end else begin
					we_nxt = 1'b1;
					idx_nxt = sf_r; // [RL21]
					wdata_nxt = quo; // [RL21]
					n_nxt = quo[15];
					z_nxt = quo == 16'h0000;
					v_nxt = 1'b0;
					c_nxt = 1'b0;
					state_nxt = muldiv_pkg::ST_DREM;
				end
			end
			muldiv_pkg::ST_DREM: begin
				we_nxt = 1'b1;
				idx_nxt = sf_r | 3'h1; // [RL21]
				wdata_nxt = dsign_r ? neg16(buffer_register_r) : buffer_register_r; // [RL21]
				state_nxt = muldiv_pkg::ST_FIN;
			end
			muldiv_pkg::ST_FIN: begin
				psw_nxt = 1'b1; // [RL19]
				state_nxt = muldiv_pkg::ST_RET;
			end
			muldiv_pkg::ST_RET: begin
				ret_nxt = 1'b1; // [RL19]
				state_nxt = muldiv_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = muldiv_pkg::ST_IDLE;
			end
		endcase
		busy_nxt = state_nxt != muldiv_pkg::ST_IDLE;
		// Aux codes follow the state they qualify, so they line up with it
		opt_nxt = (state_nxt == muldiv_pkg::ST_MLOOP || state_nxt == muldiv_pkg::ST_MLAST)
			? `OPT_AUX_LOOP : 4'h0; // [RL12]
		base_nxt = (opt_nxt == `OPT_AUX_LOOP) ? `BASE_AUX_LOOP : 5'h00; // [RL12]
	end

	// ==========================================================
	// Registers only
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_r <= muldiv_pkg::ST_IDLE;
			buffer_register_r <= 16'h0000;
			b_r <= 16'h0000;
			low_shift_register_r <= 16'h0000;
			d_r <= 16'h0000;
			destination_copy_register_r <= 16'h0000;
			src_lat_r <= 16'h0000;
			cnt_r <= 6'h00;
			sf_r <= 3'h0;
			dsign_r <= 1'b0;
			qneg_r <= 1'b0;
			busy_r <= 1'b0;
			ctl_addr_r <= 9'h000;
			option_aux_control_code_r <= 4'h0;
			base_aux_control_code_r <= 5'h00;
			option_branch_test_code_r <= 4'h0;
			direct_memory_request_clock_r <= 1'b0;
			bus_busy_clear_r <= 1'b0;
			reg_we_r <= 1'b0;
			reg_idx_r <= 3'h0;
			reg_wdata_r <= 16'h0000;
			local_negative_flag_r <= 1'b0;
			local_zero_flag_r <= 1'b0;
			local_overflow_flag_r <= 1'b0;
			local_carry_flag_r <= 1'b0;
			status_transfer_step_r <= 1'b0;
			service_return_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			buffer_register_r <= buffer_register_nxt;
			b_r <= b_nxt;
			low_shift_register_r <= low_shift_register_nxt;
			d_r <= d_nxt;
			destination_copy_register_r <= destination_copy_register_nxt;
			src_lat_r <= src_lat_nxt;
			cnt_r <= cnt_nxt;
			sf_r <= sf_nxt;
			dsign_r <= dsign_nxt;
			qneg_r <= qneg_nxt;
			busy_r <= busy_nxt;
			ctl_addr_r <= ctl_nxt;
			option_aux_control_code_r <= opt_nxt;
			base_aux_control_code_r <= base_nxt;
			option_branch_test_code_r <= bt_nxt;
			direct_memory_request_clock_r <= bus_clk_nxt;
			bus_busy_clear_r <= busy_clr_nxt;
			reg_we_r <= we_nxt;
			reg_idx_r <= idx_nxt;
			reg_wdata_r <= wdata_nxt;
			local_negative_flag_r <= n_nxt;
			local_zero_flag_r <= z_nxt;
			local_overflow_flag_r <= v_nxt;
			local_carry_flag_r <= c_nxt;
			status_transfer_step_r <= psw_nxt;
			service_return_r <= ret_nxt;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// Consecutive loop passes; a counter keeps the pass-count check cheap to unroll
	logic [4:0] loop_run_r, loop_run_nxt;

	always_comb begin
		loop_run_nxt = (state_r == muldiv_pkg::ST_MLOOP) ? 5'(loop_run_r + 5'h01) : 5'h00;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			loop_run_r <= 5'h00;
		end else begin
			loop_run_r <= loop_run_nxt;
		end
	end

	// Last pass follows exactly fifteen counted ones
	sequence seq_loop_run;
		state_r == muldiv_pkg::ST_MLAST && loop_run_r == 5'h0F;
	endsequence

	a_entry_addr: assert property (start && !busy_r && !op_div |=> ctl_addr_r == `MUL_ENTRY) // [RL2]
		else $error("multiply entry location wrong");
	a_count_gen: assert property (state_r == muldiv_pkg::ST_MSET // [RL3]
		|=> d_r == 16'h000F && buffer_register_r == 16'h000F)
		else $error("iteration count not generated");
	a_comp_step: assert property (state_r == muldiv_pkg::ST_MCOMP // [RL4]
		|=> !local_carry_flag_r && d_r == 16'(~$past(b_r) + 16'h0001))
		else $error("complement step wrong");
	a_pass_count: assert property ($rose(state_r == muldiv_pkg::ST_MLOOP) // [RL11]
		|-> ##15 seq_loop_run)
		else $error("multiply loop pass count wrong");
	a_loop_codes: assert property (state_r == muldiv_pkg::ST_MLOOP // [RL12]
		|-> option_aux_control_code_r == 4'h2 && base_aux_control_code_r == 5'h0C)
		else $error("loop aux codes missing");
	a_mn_square: assert property (state_r == muldiv_pkg::ST_MNN && src_lat_r == 16'h8000 // [RL7]
		|=> buffer_register_r == 16'h4000 && low_shift_register_r == 16'h0000
		##1 state_r == muldiv_pkg::ST_MLO)
		else $error("most negative square wrong");
	a_bus_release: assert property (state_r == muldiv_pkg::ST_MNN
		|=> direct_memory_request_clock_r && bus_busy_clear_r) // [RL13]
		else $error("bus flags not serviced");
	a_high_store: assert property (state_r == muldiv_pkg::ST_MHI // [RL14]
		|=> reg_we_r && reg_idx_r == sf_r && reg_wdata_r == buffer_register_r
		&& !local_overflow_flag_r)
		else $error("high product store wrong");
	a_odd_low: assert property (state_r == muldiv_pkg::ST_MLO // [RL1]
		|=> reg_we_r && reg_idx_r == {sf_r[2:1], 1'b1} && reg_wdata_r == low_shift_register_r)
		else $error("low product store wrong");
	a_mul_carry: assert property (state_r == muldiv_pkg::ST_MLO // [RL15]
		|-> local_carry_flag_r == !(($past(buffer_register_r) == 16'h0000
		&& !low_shift_register_r[15]) || ($past(buffer_register_r) == 16'hFFFF
		&& low_shift_register_r[15])))
		else $error("product carry wrong");
	a_psw_return: assert property (status_transfer_step_r |=> service_return_r && !busy_r) // [RL19]
		else $error("return after status transfer missing");
endmodule

// ===== hdl/muldiv_regs.svh
// Purpose: Control-store entries, codes and counts of the multiply/divide unit
// Assumes: Included by its bare name from the design files
// Notes: Microcode fields keep their printed octal values, written in hex
`ifndef MULDIV_REGS_SVH
`define MULDIV_REGS_SVH

// ==========================================================
// Control-store entry locations (octal 601 and 603)
`define MUL_ENTRY 9'h181
`define DIV_ENTRY 9'h183

// ==========================================================
// Iteration count (octal 17) and special operand values
`define ITER_COUNT 6'h0F
`define MOST_NEG 16'h8000
`define MN_SQ_HIGH 16'h4000

// ==========================================================
// Auxiliary control codes asserted during the multiply loop
`define OPT_AUX_LOOP 4'h2
`define BASE_AUX_LOOP 5'h0C

// ==========================================================
// Branch test codes (octal 3, 1, 10, 5)
`define BT_SIGN 4'h3
`define BT_D15 4'h1
`define BT_CNT0 4'h8
`define BT_DR15 4'h5

`endif

// ===== hdl/muldiv_pkg.sv
// Purpose: Types shared by the multiply/divide unit
// Assumes: Nothing is imported; users write muldiv_pkg::name
// Notes: One-hot state codes written out
package muldiv_pkg;

	// ==========================================================
	// Sequencer states
	typedef enum logic [14:0] {
		ST_IDLE = 15'h0001,
		ST_MSET = 15'h0002,
		ST_MCOMP = 15'h0004,
		ST_MNEG = 15'h0008,
		ST_MNN = 15'h0010,
		ST_MLOOP = 15'h0020,
		ST_MLAST = 15'h0040,
		ST_MHI = 15'h0080,
		ST_MLO = 15'h0100,
		ST_DSET = 15'h0200,
		ST_DLOOP = 15'h0400,
		ST_DQUO = 15'h0800,
		ST_DREM = 15'h1000,
		ST_FIN = 15'h2000,
		ST_RET = 15'h4000
	} mdu_state_t;

endpackage

// ===== hdl/booth_step.sv
// Purpose: One pass of the multiply loop: add/subtract/pass then arithmetic right shift
// Assumes: Purely combinational; caller registers the results
// Notes: A 17-bit sum keeps the true sign through the shift
`timescale 1ns/1ps
module booth_step (
	input wire logic [15:0] br_in,
	input wire logic [15:0] b_in,
	input wire logic [15:0] dr_in,
	input wire logic carry_in,
	output logic [15:0] br_out,
	output logic [15:0] dr_out,
	output logic carry_out
);
	logic [16:0] sum;

	// ==========================================================
	// ALU choice from dr_in low bit and carry, then shift
	always_comb begin
		sum = {br_in[15], br_in};
		case ({dr_in[0], carry_in})
			2'b10: sum = {br_in[15], br_in} - {b_in[15], b_in}; // [RL10] [RL9]
			2'b01: sum = {br_in[15], br_in} + {b_in[15], b_in}; // [RL10] [RL9]
			default: sum = {br_in[15], br_in}; // Pass through
		endcase
		br_out = sum[16:1]; // [RL9]
		dr_out = {sum[0], dr_in[15:1]};
		carry_out = dr_in[0]; // Old low bit steers the next pass
	end
endmodule

// ===== tb/host_core_model.sv
// Purpose: Host side of the multiply/divide unit: register file, status word, bus flags
// Assumes: Writes and status copies land on the rising edge that sees their strobe
// Notes: Operand reads are combinational, as the host presents them with start
`timescale 1ns/1ps
module host_core_model (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [2:0] src_idx,
	output logic [15:0] src_data,
	output logic [15:0] odd_data,
	input wire logic reg_we_r,
	input wire logic [2:0] reg_idx_r,
	input wire logic [15:0] reg_wdata_r,
	input wire logic [3:0] flags,
	input wire logic status_transfer_step_r,
	input wire logic direct_memory_request_clock_r,
	input wire logic bus_busy_clear_r,
	output logic [3:0] psw_r,
	output logic st_d_r,
	output int busy_clr_n
);
	logic [15:0] regs [8];

	// ==========================================================
	// Operand read ports; odd reads follow the source index
	assign src_data = regs[src_idx];
	assign odd_data = regs[src_idx | 3'h1];

	// Bench seeds registers between operations; odd index gets a last
	task automatic preload(input logic [2:0] idx, input logic [15:0] a, input logic [15:0] b);
		regs[idx | 3'h1] = b;
		regs[idx] = a;
	endtask

	// ==========================================================
	// Register writes, status copy and request flag clocking
	always @(posedge sys_clk) begin
		if (!resetn) begin
			psw_r <= 4'h0;
			st_d_r <= 1'b0;
			busy_clr_n <= 0;
		end else begin
			if (reg_we_r) begin
				regs[reg_idx_r] <= reg_wdata_r;
			end
			st_d_r <= status_transfer_step_r;
			if (status_transfer_step_r) begin
				psw_r <= flags;
			end
			// Request flags and busy clear must arrive together
			if (direct_memory_request_clock_r && bus_busy_clear_r) begin
				busy_clr_n <= busy_clr_n + 1;
			end
		end
	end
endmodule

// ===== tb/test_signed_multiply_divide_unit.sv
// Purpose: Self-checking bench of the multiply/divide unit
// Assumes: Inputs change at the falling edge; the host model holds the registers
// Notes: Table rows run back to back; refusal and mid-run reset are hand tests
`timescale 1ns/1ps
`include "muldiv_regs.svh"
module test_signed_multiply_divide_unit;
	typedef struct {
		logic op;
		logic [2:0] idx;
		logic [15:0] dst;
		logic [15:0] src;
		logic [15:0] odd;
		logic [15:0] e_a;
		logic [15:0] e_b;
		logic [3:0] e_f;
		logic chk_f;
		int e_aux;
	} row_t;

	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic start = 1'b0;
	logic op_div = 1'b0;
	logic [2:0] src_idx = 3'h0;
	logic [15:0] dst_operand = 16'h0000;
	logic [15:0] src_data, odd_data, reg_wdata_r;
	logic busy_r, reg_we_r, st_r, svc_r, dmr_r, bbc_r, st_d;
	logic n_r, z_r, v_r, c_r;
	logic [8:0] ctl_addr_r;
	logic [3:0] opt_aux, bt_code, psw_r;
	logic [4:0] base_aux;
	logic [2:0] reg_idx_r;
	int busy_clr_n;
	int aux_n;
	logic [15:0] bt_seen;
	int miscompares = 0;
	int tests_run = 0;
	row_t rows [11];

	always #2 sys_clk = ~sys_clk;

	signed_multiply_divide_unit i_dut (.sys_clk(sys_clk), .resetn(resetn), .start(start),
		.op_div(op_div), .src_idx(src_idx), .dst_operand(dst_operand), .src_data(src_data),
		.odd_data(odd_data), .busy_r(busy_r), .ctl_addr_r(ctl_addr_r),
		.option_aux_control_code_r(opt_aux), .base_aux_control_code_r(base_aux),
		.option_branch_test_code_r(bt_code), .direct_memory_request_clock_r(dmr_r),
		.bus_busy_clear_r(bbc_r), .reg_we_r(reg_we_r), .reg_idx_r(reg_idx_r),
		.reg_wdata_r(reg_wdata_r), .local_negative_flag_r(n_r), .local_zero_flag_r(z_r),
		.local_overflow_flag_r(v_r), .local_carry_flag_r(c_r), .status_transfer_step_r(st_r),
		.service_return_r(svc_r));

	host_core_model i_host (.sys_clk(sys_clk), .resetn(resetn), .src_idx(src_idx),
		.src_data(src_data), .odd_data(odd_data), .reg_we_r(reg_we_r), .reg_idx_r(reg_idx_r),
		.reg_wdata_r(reg_wdata_r), .flags({n_r, z_r, v_r, c_r}), .status_transfer_step_r(st_r),
		.direct_memory_request_clock_r(dmr_r), .bus_busy_clear_r(bbc_r), .psw_r(psw_r),
		.st_d_r(st_d), .busy_clr_n(busy_clr_n));

	// Loop passes are seen as cycles carrying both auxiliary codes
	always @(posedge sys_clk) begin
		if (opt_aux == `OPT_AUX_LOOP && base_aux == `BASE_AUX_LOOP) begin
			aux_n++;
		end
		// Branch test codes pulse for one cycle; remember which ones appeared
		if (bt_code != 4'h0) begin
			bt_seen |= 16'h0001 << bt_code;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One operation; poke > 0 retries start mid-run with other operands
	task automatic run(input row_t r, input int poke);
		int n;
		int mn0;
		logic [15:0] bt_exp;
		n = 0;
		i_host.preload(r.idx, r.src, r.odd);
		op_div = r.op;
		src_idx = r.idx;
		dst_operand = r.dst;
		start = 1'b1;
		aux_n = 0;
		bt_seen = 16'h0000;
		mn0 = busy_clr_n;
		@(negedge sys_clk);
		start = 1'b0;
		while (svc_r !== 1'b1 && n < 200) begin
			@(negedge sys_clk);
			n++;
			if (n == poke) begin
				start = 1'b1;
				dst_operand = 16'h0007;
			end else begin
				start = 1'b0;
			end
		end
		check(svc_r, 1'b1);
		check(st_d, 1'b1);
		check(i_host.regs[r.idx], r.e_a);
		check(i_host.regs[r.idx | 3'h1], r.e_b);
		check(ctl_addr_r, r.op ? `DIV_ENTRY : `MUL_ENTRY);
		if (r.chk_f) begin
			check(psw_r, r.e_f);
		end
		if (r.e_aux >= 0) begin
			check(aux_n, r.e_aux);
		end
		if (!r.op) begin
			check(busy_clr_n - mn0, (r.dst == `MOST_NEG && r.src[15]) ? 1 : 0);
		end
		// Every multiply tests sign and low product sign; divide raises no test code
		bt_exp = r.op ? 16'h0000 : ((16'h0001 << `BT_SIGN) | (16'h0001 << `BT_DR15)
			| (r.dst[15] ? (16'h0001 << `BT_D15) : 16'h0000)
			| ((r.dst == `MOST_NEG && r.src[15]) ? (16'h0001 << `BT_CNT0) : 16'h0000));
		check(bt_seen, bt_exp);
	endtask

	// Watchdog: the whole sequence needs about 1.3 us
	initial begin
		#20000;
		miscompares++;
		test_done();
	end

	initial begin
		// ==========================================================
		// Table of operations: multiply cases then divide cases
		rows[0] = '{1'b0, 3'h0, 16'h0003, 16'h0005, 16'hA5A5, 16'h0000, 16'h000F, 4'h0, 1'b1, 16};
		rows[1] = '{1'b0, 3'h2, 16'hFFFD, 16'h0005, 16'hA5A5, 16'hFFFF, 16'hFFF1, 4'h8, 1'b1, 16};
		rows[2] = '{1'b0, 3'h4, 16'h8000, 16'h8000, 16'hA5A5, 16'h4000, 16'h0000, 4'h1, 1'b1, 0};
		rows[3] = '{1'b0, 3'h6, 16'h8000, 16'h0002, 16'hA5A5, 16'hFFFF, 16'h0000, 4'h9, 1'b1, 16};
		rows[4] = '{1'b0, 3'h0, 16'h8000, 16'hFFFF, 16'hA5A5, 16'h0000, 16'h8000, 4'h1, 1'b1, 16};
		rows[5] = '{1'b0, 3'h2, 16'h0000, 16'h1234, 16'hA5A5, 16'h0000, 16'h0000, 4'h4, 1'b1, 16};
		rows[6] = '{1'b0, 3'h5, 16'h7FFF, 16'h7FFF, 16'hA5A5, 16'h0001, 16'h0001, 4'h1, 1'b1, 16};
		rows[7] = '{1'b0, 3'h0, 16'h1234, 16'h8000, 16'hA5A5, 16'hF6E6, 16'h0000, 4'h9, 1'b1, 16};
		rows[8] = '{1'b1, 3'h0, 16'h0007, 16'h0000, 16'h0064, 16'h000E, 16'h0002, 4'h0, 1'b0, -1};
		rows[9] = '{1'b1, 3'h2, 16'h0007, 16'hFFFF, 16'hFF9C, 16'hFFF2, 16'hFFFE, 4'h0, 1'b0, -1};
		rows[10] = '{1'b1, 3'h4, 16'h0000, 16'h0000, 16'h0005, 16'h0000, 16'h0005, 4'h7, 1'b1, -1};
		repeat (6) @(negedge sys_clk);
		resetn = 1'b1;
		check({busy_r, reg_we_r, st_r, svc_r, n_r, z_r, v_r, c_r}, 8'h00);
		check(ctl_addr_r, 9'h000);
		foreach (rows[i]) begin
			run(rows[i], -1);
		end
		// A start while busy is ignored; the result is still 3 times 5
		run(rows[0], 4);
		// Reset in mid-run: nothing written, outputs cleared, then recovery
		@(negedge sys_clk);
		i_host.preload(3'h6, 16'h0011, 16'hA5A5);
		src_idx = 3'h6;
		op_div = 1'b0;
		dst_operand = 16'h0003;
		start = 1'b1;
		@(negedge sys_clk);
		start = 1'b0;
		repeat (5) @(negedge sys_clk);
		resetn = 1'b0;
		repeat (2) @(negedge sys_clk);
		check({busy_r, reg_we_r, opt_aux}, 6'h00);
		check(ctl_addr_r, 9'h000);
		resetn = 1'b1;
		repeat (30) @(negedge sys_clk);
		check(i_host.regs[6], 16'h0011);
		check(i_host.regs[7], 16'hA5A5);
		run(rows[1], -1);
		test_done();
	end
endmodule
